/* verilog/acc_conv_ctrl.sv */
// Operation
// (RULE_01) hardware sets the done flag, bit 7, when a conversion cycle ends
// (RULE_02) taking the converter interrupt vector clears the done flag
// (RULE_03) software clears the done flag itself when polling
// (RULE_04) writing 1 to bit 6 starts the prepared DMA capture mode
// (RULE_05) the DMA bit returns to 0 when the DMA cycle completes
// (RULE_06) while the DMA bit is set no address latch strobes go out
// (RULE_07) writing 1 to bit 5 selects continuous conversion
// (RULE_08) continuous mode keeps converting with the current timing and channel
// (RULE_09) continuous mode restarts right after each finished conversion
// (RULE_10) writing 1 to bit 4 performs exactly one conversion
// (RULE_11) software conversions use the channel in bits 3 to 0
// (RULE_12) DMA conversions take the channel from capture memory instead
// (RULE_13) codes 0-7 inputs, then temp, dac0, dac1, agnd, vref; all ones stops DMA
// (RULE_14) result high byte carries the channel in its top four bits
// (RULE_15) the single request bit clears when its conversion ends
`timescale 1ns/1ps

module acc_conv_ctrl
    import acc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              intAck,
    output logic                   doneFlag,
    input  wire logic              aleIn,
    output logic                   aleOut,
    output acc_conv_req_s          convReq,
    input  wire acc_conv_res_s     convRes,
    input  wire acc_dma_req_s      dmaReq,
    output logic                   dmaAck,
    output logic                   dmaStart,
    output logic                   dmaActive,
    input  wire logic              dmaDone,
    output acc_result_s            result
);

    logic [7:0]        ctrl;
    logic [7:0]        next_ctrl;
    acc_seq_e          seq;
    logic              curSingle;
    logic              curDma;
    logic              awHeld;
    logic              wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [7:0]        wByte;
    logic              wLane;
    logic              wrDo;
    logic              wrCtrl;
    logic              startDma;
    logic              dmaStop;
    logic              startSw;
    logic              convEnd;
    logic              dmaEnd;
    logic              doneEvt;

    assign doneFlag  = ctrl[FLAG_BIT];
    assign dmaActive = ctrl[DMA_BIT];

    // ---- AXI4-Lite write path
    assign wrDo   = awHeld && wHeld && !bvalid;
    assign wrCtrl = wrDo && (awAddr == CTRL_OFS) && wLane;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            awHeld  <= 1'b0;
            awAddr  <= '0;
            awready <= 1'b1;
        end else if (awvalid && awready) begin
            awHeld  <= 1'b1;
            awAddr  <= awaddr;
            awready <= 1'b0;
        end else if (wrDo) begin
            awHeld  <= 1'b0;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wHeld  <= 1'b0;
            wByte  <= '0;
            wLane  <= 1'b0;
            wready <= 1'b1;
        end else if (wvalid && wready) begin
            wHeld  <= 1'b1;
            wByte  <= wdata[7:0];
            wLane  <= wstrb[0];
            wready <= 1'b0;
        end else if (wrDo) begin
            wHeld  <= 1'b0;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // result register is read only, so only the control word accepts writes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wrDo) begin
            bvalid <= 1'b1;
            bresp  <= (awAddr == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ---- AXI4-Lite read path
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= RESP_OKAY;
            unique case (araddr)
                CTRL_OFS:   rdata <= {24'h000000, ctrl};
                RESULT_OFS: rdata <= {16'h0000, result};
                default: begin
                    rdata <= '0;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ---- sequencer events
    assign startDma = (seq == SEQ_IDLE) && ctrl[DMA_BIT] && dmaReq.valid
                      && (dmaReq.channel != CH_DMA_STOP);       // see (RULE_12)
    assign dmaStop  = (seq == SEQ_IDLE) && ctrl[DMA_BIT] && dmaReq.valid
                      && (dmaReq.channel == CH_DMA_STOP);       // see (RULE_13)
    assign startSw  = (seq == SEQ_IDLE) && !ctrl[DMA_BIT]
                      && (ctrl[SINGLE_BIT] || ctrl[CONT_BIT]);  // see (RULE_07)
    assign convEnd  = (seq == SEQ_CONV) && convRes.done;
    assign dmaEnd   = ctrl[DMA_BIT] && (dmaDone || dmaStop);
    assign doneEvt  = (convEnd && !curDma) || dmaEnd;           // see (RULE_01)

    // ---- control register
    always_comb begin
        next_ctrl = ctrl;
        if (wrCtrl) begin
            next_ctrl = wByte;                                  // see (RULE_03)
        end
        if (intAck) begin
            next_ctrl[FLAG_BIT] = 1'b0;                         // see (RULE_02)
        end
        if (convEnd && curSingle) begin
            next_ctrl[SINGLE_BIT] = 1'b0;                       // see (RULE_15)
        end
        if (dmaEnd) begin
            next_ctrl[DMA_BIT] = 1'b0;                          // see (RULE_05)
        end
        // a finishing software conversion or DMA cycle end beats a clear in the same cycle
        if (doneEvt) begin
            next_ctrl[FLAG_BIT] = 1'b1;                         // see (RULE_01)
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= CTRL_RST;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ---- DMA engine handshakes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dmaStart <= 1'b0;
            dmaAck   <= 1'b0;
        end else begin
            dmaStart <= wrCtrl && wByte[DMA_BIT] && !ctrl[DMA_BIT]; // see (RULE_04)
            dmaAck   <= startDma || dmaStop;
        end
    end

    // strobe is cut off while capture owns the external bus
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            aleOut <= 1'b0;
        end else begin
            aleOut <= aleIn && !ctrl[DMA_BIT];                  // see (RULE_06)
        end
    end

    // ---- conversion sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            seq       <= SEQ_IDLE;
            convReq   <= '0;
            curSingle <= 1'b0;
            curDma    <= 1'b0;
        end else begin
            convReq.start <= 1'b0;
            unique case (seq)
                SEQ_IDLE: begin
                    if (startDma) begin
                        convReq.start   <= 1'b1;
                        convReq.channel <= dmaReq.channel;      // see (RULE_12)
                        curDma          <= 1'b1;
                        curSingle       <= 1'b0;
                        seq             <= SEQ_CONV;
                    end else if (startSw) begin
                        // continuous mode restarts here without software help
                        convReq.start   <= 1'b1;                // see (RULE_09)
                        convReq.channel <= ctrl[CS_MSB:CS_LSB]; // see (RULE_11) (RULE_08)
                        curDma          <= 1'b0;
                        curSingle       <= ctrl[SINGLE_BIT];    // see (RULE_10)
                        seq             <= SEQ_CONV;
                    end
                end
                SEQ_CONV: begin
                    if (convRes.done) begin
                        seq <= SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    // ---- result register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            result <= '0;
        end else if (convEnd) begin
            result.high <= {convReq.channel, convRes.data[RES_W-1:8]}; // see (RULE_14)
            result.low  <= convRes.data[7:0];
        end
    end

    // ---- checks
    a_flag_set: assert property (                               // see (RULE_01)
        @(posedge ref_clk) disable iff (!rstn)
        doneEvt |=> doneFlag)
        else $error("done flag not set after conversion end");

    a_flag_vector: assert property (                            // see (RULE_02)
        @(posedge ref_clk) disable iff (!rstn)
        intAck && !doneEvt |=> !doneFlag)
        else $error("done flag survived interrupt vectoring");

    a_dma_kick: assert property (                               // see (RULE_04)
        @(posedge ref_clk) disable iff (!rstn)
        $rose(dmaActive) |-> dmaStart && $past(wrCtrl))
        else $error("dma mode entered without start pulse");

    a_dma_finish: assert property (                             // see (RULE_05)
        @(posedge ref_clk) disable iff (!rstn)
        dmaActive && dmaDone |=> !dmaActive)
        else $error("dma bit not cleared at end of capture");

    a_ale_quiet: assert property (                              // see (RULE_06)
        @(posedge ref_clk) disable iff (!rstn)
        dmaActive |=> !aleOut)
        else $error("address latch strobe during dma");

    a_cont_restart: assert property (                           // see (RULE_09)
        @(posedge ref_clk) disable iff (!rstn)
        convEnd && ctrl[CONT_BIT] && !dmaActive && !wrCtrl
            |=> ##1 convReq.start)
        else $error("continuous mode did not restart");

    a_single_clear: assert property (                           // see (RULE_15)
        @(posedge ref_clk) disable iff (!rstn)
        convEnd && curSingle |=> !ctrl[SINGLE_BIT])
        else $error("single request bit left set");

    a_sw_channel: assert property (                             // see (RULE_11)
        @(posedge ref_clk) disable iff (!rstn)
        startSw |=> convReq.start
            && convReq.channel == $past(ctrl[CS_MSB:CS_LSB]))
        else $error("software conversion used wrong channel");

    a_dma_channel: assert property (                            // see (RULE_12)
        @(posedge ref_clk) disable iff (!rstn)
        startDma |=> convReq.start && dmaAck
            && convReq.channel == $past(dmaReq.channel))
        else $error("dma conversion used wrong channel");

    a_dma_stop: assert property (                               // see (RULE_13)
        @(posedge ref_clk) disable iff (!rstn)
        dmaStop |=> !dmaActive && !convReq.start && doneFlag)
        else $error("stop marker did not end dma");

    a_result_tag: assert property (                             // see (RULE_14)
        @(posedge ref_clk) disable iff (!rstn)
        convEnd |=> result.high[7:4] == $past(convReq.channel))
        else $error("result not tagged with channel");

    a_cont_channel: assert property (                           // see (RULE_08)
        @(posedge ref_clk) disable iff (!rstn)
        seq == SEQ_IDLE && ctrl[CONT_BIT] && !dmaActive |=> convReq.start
            && convReq.channel == $past(ctrl[CS_MSB:CS_LSB]))
        else $error("continuous mode stalled or changed channel");

    a_single_once: assert property (                            // see (RULE_10)
        @(posedge ref_clk) disable iff (!rstn)
        convEnd && curSingle && !ctrl[CONT_BIT] && !dmaActive && !wrCtrl
            |=> !convReq.start ##1 !convReq.start)
        else $error("single request converted more than once");

    a_ale_pass: assert property (                               // see (RULE_06)
        @(posedge ref_clk) disable iff (!rstn)
        !dmaActive |=> aleOut == $past(aleIn))
        else $error("address latch strobe not passed through");

    a_dma_ignore_sw: assert property (                          // see (RULE_12)
        @(posedge ref_clk) disable iff (!rstn)
        seq == SEQ_IDLE && dmaActive && !dmaReq.valid |=> !convReq.start)
        else $error("conversion started in dma mode without request");

    a_result_data: assert property (                            // see (RULE_14)
        @(posedge ref_clk) disable iff (!rstn)
        convEnd |=> result[RES_W-1:0] == $past(convRes.data))
        else $error("result does not carry conversion data");

    a_dma_hold: assert property (                               // see (RULE_04)
        @(posedge ref_clk) disable iff (!rstn)
        dmaActive && !dmaEnd && !wrCtrl |=> dmaActive)
        else $error("dma mode dropped without an end event");

endmodule : acc_conv_ctrl

/* include/acc_pkg.sv */
package acc_pkg;

    // register bus geometry
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;

    // register byte offsets
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  RESULT_OFS  = 8'h04;

    // control register layout and reset value
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam int          FLAG_BIT    = 7;
    localparam int          DMA_BIT     = 6;
    localparam int          CONT_BIT    = 5;
    localparam int          SINGLE_BIT  = 4;
    localparam int          CS_MSB      = 3;
    localparam int          CS_LSB      = 0;

    // channel codes: 0..7 inputs, 8 temp, 9 dac0, A dac1, B agnd, C vref
    localparam logic [3:0]  CH_DMA_STOP = 4'hF;

    // result high byte layout
    localparam int          RES_W       = 12;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum {
        SEQ_IDLE,
        SEQ_CONV
    } acc_seq_e;

    typedef struct packed {
        logic       start;
        logic [3:0] channel;
    } acc_conv_req_s;

    typedef struct packed {
        logic              done;
        logic [RES_W-1:0]  data;
    } acc_conv_res_s;

    typedef struct packed {
        logic       valid;
        logic [3:0] channel;
    } acc_dma_req_s;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } acc_result_s;

endpackage : acc_pkg

/* bench/acc_conv_ctrl_bench.sv */
`timescale 1ns/1ps

module acc_conv_ctrl_bench;
    import acc_pkg::*;

    logic              ref_clk, rstn, intAck, aleIn, dmaDone;
    logic              awvalid, wvalid, bready, arvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0]        wstrb, lastCh;
    logic [1:0]        bresp, rresp;
    logic              awready, wready, bvalid, arready, rvalid;
    logic              doneFlag, aleOut, dmaAck, dmaStart, dmaActive;
    acc_conv_req_s     convReq;
    acc_conv_res_s     convRes;
    acc_dma_req_s      dmaReq;
    acc_result_s       result;
    int                n_fail, comparisons, nStart, nDma;

    acc_conv_ctrl dut_u (
        .ref_clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .intAck, .doneFlag, .aleIn, .aleOut, .convReq, .convRes, .dmaReq,
        .dmaAck, .dmaStart, .dmaActive, .dmaDone, .result
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // pulses are counted mid-cycle, where every flop output has settled
    always @(negedge ref_clk) begin
        if (convReq.start === 1'b1) begin
            nStart++;
            lastCh = convReq.channel;
        end
        if (dmaStart === 1'b1) nDma++;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge ref_clk);
            if (awready === 1'b1) aw = 1'b0;
            if (wready === 1'b1) w = 1'b0;
            @(posedge ref_clk);
            awvalid <= aw;
            wvalid <= w;
        end while (aw || w);
        // only the watchdog ends a wait for the response
        do begin
            @(negedge ref_clk);
        end while (bvalid !== 1'b1);
        r = bresp;
        @(posedge ref_clk);
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge ref_clk);
        end while (arready !== 1'b1);
        @(posedge ref_clk);
        arvalid <= 1'b0;
        do begin
            @(negedge ref_clk);
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge ref_clk);
        rready <= 1'b0;
    endtask : axi_read

    task automatic conv_done(input logic [11:0] v);
        @(posedge ref_clk);
        convRes <= '{1'b1, v};
        @(posedge ref_clk);
        convRes <= '0;
    endtask : conv_done

    task automatic dma_req(input logic [3:0] ch);
        @(posedge ref_clk);
        dmaReq <= '{1'b1, ch};
        do begin
            @(negedge ref_clk);
        end while (dmaAck !== 1'b1);
        @(posedge ref_clk);
        dmaReq <= '0;
        // the acknowledge stands for one cycle only
        @(negedge ref_clk);
        chk("dma ack pulse", 0, dmaAck);
    endtask : dma_req

    task automatic t_single();
        logic [31:0] d;
        logic [1:0]  r;
        int          s0;
        s0 = nStart;
        axi_write(CTRL_OFS, 32'h13, r);
        chk("write resp", RESP_OKAY, r);
        cyc(3);
        chk("single channel", 4'h3, lastCh);
        conv_done(12'hABC);
        cyc(6);
        chk("start count", s0 + 1, nStart);
        chk("result", 16'h3ABC, result);
        chk("flag set", 1, doneFlag);
        axi_read(CTRL_OFS, d, r);
        chk("ctrl after single", 32'h83, d);
        chk("read resp", RESP_OKAY, r);
        axi_read(RESULT_OFS, d, r);
        chk("result reg", 32'h3ABC, d);
        @(posedge ref_clk);
        intAck <= 1'b1;
        @(posedge ref_clk);
        intAck <= 1'b0;
        cyc(2);
        chk("flag after ack", 0, doneFlag);
    endtask : t_single

    task automatic t_cont();
        logic [1:0] r;
        int         s0;
        s0 = nStart;
        axi_write(CTRL_OFS, 32'h25, r);
        cyc(3);
        chk("cont channel", 4'h5, lastCh);
        conv_done(12'h001);
        // restart launched one edge after done is taken
        cyc(4);
        chk("auto restart", s0 + 2, nStart);
        chk("cont channel again", 4'h5, lastCh);
        axi_write(CTRL_OFS, 32'h05, r);
        cyc(1);
        chk("flag cleared by write", 0, doneFlag);
        conv_done(12'h002);
        cyc(8);
        chk("no restart after stop", s0 + 2, nStart);
    endtask : t_cont

    task automatic t_dma();
        logic [31:0] d;
        logic [1:0]  r;
        int          s0;
        axi_write(CTRL_OFS, 32'h42, r);
        cyc(2);
        chk("dma start pulse", 1, nDma);
        chk("dma active", 1, dmaActive);
        chk("strobe held off", 0, aleOut);
        dma_req(4'h9);
        cyc(2);
        chk("dma channel", 4'h9, lastCh);
        conv_done(12'h123);
        @(posedge ref_clk);
        dmaDone <= 1'b1;
        @(posedge ref_clk);
        dmaDone <= 1'b0;
        cyc(3);
        axi_read(CTRL_OFS, d, r);
        chk("ctrl after dma", 32'h82, d);
        chk("strobe back", 1, aleOut);
        axi_write(CTRL_OFS, 32'h40, r);
        s0 = nStart;
        dma_req(CH_DMA_STOP);
        cyc(4);
        chk("stop marker no conversion", s0, nStart);
        axi_read(CTRL_OFS, d, r);
        chk("ctrl after stop marker", 32'h80, d);
    endtask : t_dma

    task automatic t_bus();
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(8'h08, d, r);
        chk("unmapped read resp", RESP_SLVERR, r);
        chk("unmapped read data", 0, d);
        axi_write(RESULT_OFS, 32'h10, r);
        chk("read-only write resp", RESP_SLVERR, r);
        axi_read(CTRL_OFS, d, r);
        chk("ctrl untouched", 32'h80, d);
    endtask : t_bus

    task automatic report_and_stop();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        {rstn, intAck, dmaDone, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        aleIn = 1'b1;
        convRes = '0;
        dmaReq = '0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        axi_read(CTRL_OFS, d, r);
        chk("ctrl reset", {24'h0, CTRL_RST}, d);
        chk("strobe passes", 1, aleOut);
        t_single();
        t_cont();
        t_dma();
        t_bus();
        report_and_stop();
    end

    // whole sequence needs well under a thousand cycles
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end

endmodule : acc_conv_ctrl_bench
